// ==== rtl/boot_cfg_pkg.sv ====
// Shared constants, carriers and helpers for the boot configuration readback block.
// Assumes one processor bus clock domain and a synchronous, active-high reset.
package boot_cfg_pkg;

  // Address map of the register range and the firmware memories
  localparam logic [31:0] CFG_REG_BASE  = 32'h2008_4000;
  localparam logic [31:0] CFG_REG_BYTES = 32'h0000_0080;  // 32 longwords
  localparam logic [31:0] EPROM_BASE    = 32'h2004_0000;
  localparam logic [31:0] EPROM_BYTES   = 32'h0004_0000;  // 256 kilobytes
  localparam logic [31:0] NVRAM_BASE    = 32'h2014_0400;
  localparam logic [31:0] NVRAM_BYTES   = 32'h0000_0400;  // 1 kilobyte
  localparam int          NVRAM_WORDS   = 256;

  // Field positions inside the configuration longword
  localparam int F_REMOTE_BOOT = 31;
  localparam int F_CABLE_FAULT = 30;
  localparam int F_EXT_NODE_LO = 24;
  localparam int F_INT_NODE_LO = 16;
  localparam int F_STATION_LO  = 8;
  localparam int F_HALT_ALLOW  = 7;
  localparam int F_BAUD_LO     = 4;
  localparam int F_TEST_POINT  = 3;
  localparam int F_CONST_ONE   = 2;
  localparam int F_MODE_LO     = 0;

  // Reset values and timing counts
  localparam logic       CONST_ONE_VALUE   = 1'b1;
  localparam logic       CABLE_FAULT_RESET = 1'b1;
  localparam logic [3:0] PROBE_LAST        = 4'hF;  // Probe toggles every 16 cycles

  // Access width of a processor reference
  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} xfer_size_t;

  // One processor reference
  typedef struct packed {
    logic        req;
    logic        wr;
    logic        ext_master;
    xfer_size_t  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bus_req_t;

  // Switch, jumper and test-point levels from the console module and backplane
  typedef struct packed {
    logic       remote_boot_off;
    logic       cable_return;
    logic [2:0] external_storage_node_id;
    logic [2:0] internal_storage_node_id;
    logic       halt_on_break_allow;
    logic [2:0] baud_switch_code;
    logic       test_point;
    logic [1:0] powerup_mode_code;
    logic       break_detect;
  } switch_in_t;

  // Byte lanes touched by a reference of the given size
  function automatic logic [3:0] lane_mask(xfer_size_t sz, logic [1:0] a);
    logic [3:0] m;
    m = 4'hF;
    if (sz == SZ_BYTE) m = 4'h1 << a;
    else if (sz == SZ_WORD) m = a[1] ? 4'hC : 4'h3;
    return m;
  endfunction

  // True when the address falls in [base, base+bytes)
  function automatic logic in_range(logic [31:0] a, logic [31:0] base, logic [31:0] bytes);
    logic [31:0] off;
    off = a - base;
    return off < bytes;
  endfunction

endpackage

// ==== rtl/level_sync.sv ====
// Two-flop synchroniser for a bundle of slow levels.
// Assumes the levels change far slower than the clock; bits are not coherent.
`timescale 1ns/1ps
module level_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] held;
  } sync_t;

  sync_t r;
  sync_t n;

  // First stage feeds only the second stage
  always_comb begin
    n      = r;
    n.meta = d;
    n.held = r.meta;
  end

  always_ff @(posedge clk) begin
    if (srst) r <= '0;
    else      r <= n;
  end

  assign q = r.held;

endmodule // level_sync

// ==== rtl/boot_config_readback.sv ====
// Boot configuration readback register, firmware EPROM port and battery RAM.
// Assumes a single processor bus master port; EPROM contents sit outside.
//
// Overview of operation
// [RQ1] Register answers 32 longwords from base 2008 4000 upward.
// [RQ2] Bits 7:0 and 31:16 read the same at every offset.
// [RQ3] Bits 15:8 step through ROM: six address bytes, then two checksum bytes.
// [RQ4] Offsets beyond the first eight return ROM test pattern bytes.
// [RQ5] Own processor only; external expansion-bus masters get no answer.
// [RQ6] Bit 31 mirrors remote boot jumper; 1 ignores remote boot requests.
// [RQ7] Bit 30 is cable loopback result: 0 good, 1 faulty or reversed.
// [RQ8] Bits 26:24 give external storage bus node number.
// [RQ9] Bits 18:16 give internal storage bus node number.
// [RQ10] Software must not rely on or write bits 29:27 and 23:19.
// [RQ11] Bit 7 mirrors break-enable switch, read-only.
// [RQ12] Break halts processor only while halt-on-break bit is set.
// [RQ13] Firmware at power-up picks console or boot from halt bit.
// [RQ14] Firmware after kernel halt picks console or restart from halt bit.
// [RQ15] EPROM and battery RAM accept longword, word and byte reads.
// [RQ16] Bits 6:4 mirror baud switch, 111 slowest to 000 fastest.
// [RQ17] Bit 3 mirrors manufacturing test point, read-only.
// [RQ18] Bit 2 always reads one.
// [RQ19] Bits 1:0 mirror power-up mode switch.
// [RQ20] Writes to the register range complete but change nothing.
// [RQ21] Switch inputs are synchronised before being returned.
`timescale 1ns/1ps
module boot_config_readback
  import boot_cfg_pkg::*;
#(
  parameter logic [255:0] STATION_IMAGE = {32{8'hA5}}  // Arbitrary neutral ROM image
) (
  input  wire logic                     MCLK,
  input  wire logic                     SRST,
  input  wire boot_cfg_pkg::bus_req_t   BUS,
  input  wire boot_cfg_pkg::switch_in_t SW,
  input  wire logic [31:0]              ROM_DATA,
  output logic                          BUSY,
  output logic                          ACK,
  output logic [31:0]                   RDATA,
  output logic [15:0]                   ROM_ADDR,
  output logic                          CABLE_PROBE,
  output logic                          HALT_REQ
);
  import boot_cfg_pkg::*;

  typedef enum logic {ST_IDLE, ST_ACCESS} st_t;

  typedef struct packed {
    st_t         st;
    logic [31:0] addr;
    xfer_size_t  size;
    logic        wr;
    logic [31:0] wdata;
    logic        hit_cfg;
    logic        hit_rom;
    logic        hit_ram;
    logic        ack;
    logic [31:0] rdata;
    logic [15:0] rom_addr;
    logic [3:0]  cnt;
    logic        probe;
    logic        fault;
    logic        halt;
  } state_t;

  state_t      r;
  state_t      n;
  switch_in_t  sw_s;
  logic [31:0] cfg_word;
  logic [31:0] src_word;
  logic [31:0] lane_bits;
  logic [3:0]  m;
  logic [7:0]  station_byte;
  logic        hit_any;
  logic [31:0] nvram [NVRAM_WORDS];

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation

  // Jumpers and switches are slow levels; two flops suffice
  level_sync #(
    .W ($bits(switch_in_t))
  ) u_sync (
    .clk  (MCLK),
    .srst (SRST),
    .d    (SW),
    .q    (sw_s)                                                   // RQ21
  );

  ////////////////////////////////////////////////////////////////////////////
  // Configuration word

  // Station ROM byte chosen by longword index within the range
  assign station_byte = STATION_IMAGE[{r.addr[6:2], 3'b000} +: 8]; // RQ3 RQ4

  // Same upper word and low byte at every offset; undefined bits read zero
  always_comb begin
    cfg_word                                    = '0;                            // RQ2
    cfg_word[F_REMOTE_BOOT]                     = sw_s.remote_boot_off;          // RQ6
    cfg_word[F_CABLE_FAULT]                     = r.fault;                       // RQ7
    cfg_word[F_EXT_NODE_LO +: 3]                = sw_s.external_storage_node_id; // RQ8
    cfg_word[F_INT_NODE_LO +: 3]                = sw_s.internal_storage_node_id; // RQ9
    cfg_word[F_STATION_LO +: 8]                 = station_byte;                  // RQ3
    cfg_word[F_HALT_ALLOW]                      = sw_s.halt_on_break_allow;      // RQ11
    cfg_word[F_BAUD_LO +: 3]                    = sw_s.baud_switch_code;         // RQ16
    cfg_word[F_TEST_POINT]                      = sw_s.test_point;               // RQ17
    cfg_word[F_CONST_ONE]                       = CONST_ONE_VALUE;               // RQ18
    cfg_word[F_MODE_LO +: 2]                    = sw_s.powerup_mode_code;        // RQ19
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access path

  // Only the local processor is answered; external masters fall through
  assign hit_any = in_range(BUS.addr, CFG_REG_BASE, CFG_REG_BYTES)
                 | in_range(BUS.addr, EPROM_BASE, EPROM_BYTES)
                 | in_range(BUS.addr, NVRAM_BASE, NVRAM_BYTES);

  // Source longword for the latched reference
  always_comb begin
    m         = lane_mask(r.size, r.addr[1:0]);
    lane_bits = {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
    src_word  = '0;
    if (r.hit_cfg)      src_word = cfg_word;
    else if (r.hit_rom) src_word = ROM_DATA;
    else if (r.hit_ram) src_word = nvram[r.addr[9:2]];
  end

  // Take a reference, answer it one cycle later, run the cable probe
  always_comb begin
    n     = r;
    n.ack = 1'b0;
    unique case (r.st)
      ST_IDLE: begin
        if (BUS.req && !BUS.ext_master && hit_any) begin              // RQ5
          n.st       = ST_ACCESS;
          n.addr     = BUS.addr;
          n.size     = BUS.size;
          n.wr       = BUS.wr;
          n.wdata    = BUS.wdata;
          n.hit_cfg  = in_range(BUS.addr, CFG_REG_BASE, CFG_REG_BYTES); // RQ1
          n.hit_rom  = in_range(BUS.addr, EPROM_BASE, EPROM_BYTES);
          n.hit_ram  = in_range(BUS.addr, NVRAM_BASE, NVRAM_BYTES);
          n.rom_addr = BUS.addr[17:2];
        end
      end
      ST_ACCESS: begin
        n.st  = ST_IDLE;
        n.ack = 1'b1;
        // Writes return zero and leave every mirrored field alone
        if (r.wr) n.rdata = '0;                                        // RQ20
        else      n.rdata = src_word & lane_bits;                      // RQ15
      end
    endcase
    // Probe level settles through the cable and the synchroniser first
    n.cnt = r.cnt + 4'h1;
    if (r.cnt == PROBE_LAST) begin
      n.fault = sw_s.cable_return != r.probe;                          // RQ7
      n.probe = !r.probe;
    end
    // Break stops the processor only while the switch allows it
    n.halt = sw_s.break_detect & sw_s.halt_on_break_allow;             // RQ12
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      r       <= '0;
      r.st    <= ST_IDLE;
      r.size  <= SZ_LONG;
      r.fault <= CABLE_FAULT_RESET;
    end else begin
      r <= n;
    end
  end

  // Battery RAM takes byte-lane writes; EPROM writes are dropped
  always_ff @(posedge MCLK) begin
    if (r.st == ST_ACCESS && r.wr && r.hit_ram) begin
      for (int i = 0; i < 4; i++) begin
        if (m[i]) nvram[r.addr[9:2]][i*8 +: 8] <= r.wdata[i*8 +: 8];
      end
    end
  end

  assign BUSY        = r.st == ST_ACCESS;
  assign ACK         = r.ack;
  assign RDATA       = r.rdata;
  assign ROM_ADDR    = r.rom_addr;
  assign CABLE_PROBE = r.probe;
  assign HALT_REQ    = r.halt;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);

  logic take;
  assign take = BUS.req && !BUS.ext_master && hit_any && r.st == ST_IDLE;

  reg_answer_a: assert property (take |=> ##1 ACK) // RQ1
    else $error("Mapped local reference not answered in two cycles");

  ext_ignored_a: assert property (
    (BUS.req && BUS.ext_master && r.st == ST_IDLE) |=> ##1 !ACK) // RQ5
    else $error("External master reference was answered");

  const_one_a: assert property (
    (take && in_range(BUS.addr, CFG_REG_BASE, CFG_REG_BYTES) && !BUS.wr
     && BUS.size == SZ_LONG) |=> ##1 RDATA[F_CONST_ONE]) // RQ18
    else $error("Constant one bit read as zero");

  fields_same_a: assert property (
    (ACK && $past(r.hit_cfg) && !$past(r.wr) && $past(r.size) == SZ_LONG)
    |-> {RDATA[31:16], RDATA[7:0]} == $past({cfg_word[31:16], cfg_word[7:0]})) // RQ2
    else $error("Upper word or low byte differs from live fields");

  station_byte_a: assert property (
    (ACK && $past(r.hit_cfg) && !$past(r.wr) && $past(r.size) == SZ_LONG)
    |-> RDATA[15:8] == STATION_IMAGE[{$past(r.addr[6:2]), 3'b000} +: 8]) // RQ3
    else $error("Station byte does not follow longword index");

  write_zero_a: assert property (
    (take && BUS.wr) |=> ##1 (ACK && RDATA == 32'h0000_0000)) // RQ20
    else $error("Write answer not clean");

  byte_lane_a: assert property (
    (ACK && $past(r.size) == SZ_BYTE)
    |-> (RDATA & ~(32'h0000_00FF << {$past(r.addr[1:0]), 3'b000})) == '0) // RQ15
    else $error("Byte read leaked other lanes");

  halt_gate_a: assert property (
    !sw_s.halt_on_break_allow |=> !HALT_REQ) // RQ12
    else $error("Halt raised while halt on break disallowed");

  // Either of the last two edges in reset clears a synchroniser stage
  sync_delay_a: assert property (
    (!$past(SRST) && !$past(SRST, 2))
    |-> sw_s.powerup_mode_code == $past(SW.powerup_mode_code, 2)) // RQ21
    else $error("Mode switch not delayed by two flops");

  cable_check_a: assert property (
    (r.cnt == PROBE_LAST) |=> r.fault == ($past(sw_s.cable_return) != $past(r.probe))) // RQ7
    else $error("Cable fault does not match loopback compare");

  reg_read_c: cover property (take && !BUS.wr && BUS.addr[6:5] != 2'b00);
  ram_write_c: cover property (take && BUS.wr && BUS.size == SZ_BYTE);
  halt_c: cover property (HALT_REQ);
  fault_clear_c: cover property (r.fault ##1 !r.fault);

endmodule // boot_config_readback

// ==== testbench/boot_config_readback_test.sv ====
// Self-checking bench for the boot configuration readback block.
// Assumes the design package is compiled first; bench acts as processor, switches and EPROM.
`timescale 1ns/1ps
module boot_config_readback_test;
  import boot_cfg_pkg::*;
  // Distinct ROM bytes so a wrong index shows; byte i holds 40 plus i
  localparam logic [255:0] IMG =
    256'h5F5E5D5C_5B5A5958_57565554_53525150_4F4E4D4C_4B4A4948_47464544_43424140;
  // Skips cable bit and the undefined bits that software must not rely on
  localparam logic [31:0] CMP_MASK = 32'h8707_FFFF;
  logic        MCLK     = 1'b0;
  logic        SRST     = 1'b1;
  bus_req_t    bus      = '0;
  switch_in_t  sw_in    = '0;
  logic [15:0] sw_base  = 16'h0000;
  logic        cab_mode = 1'b0;
  logic [31:0] rom_data;
  logic        busy;
  logic        ack;
  logic [31:0] rdata;
  logic [15:0] rom_addr;
  logic        probe;
  logic        halt;
  int          error_cnt = 0;
  int          n_tests   = 0;
  int          cyc       = 0;
  integer      seed      = 32'hBF7F;
  logic [31:0] rd;
  logic [31:0] v;
  logic [31:0] a;
  logic        ok;
  xfer_size_t  sz;
  logic [31:0] e;
  logic        busy_seen;
  int          ack_cnt;

  always #25 MCLK = ~MCLK;
  // EPROM model: data is a pure function of the index, so any index slip shows
  assign rom_data = {rom_addr, ~rom_addr};
  // Cable loop: straight or reversed return of the probe
  always @(negedge MCLK) sw_in <= {sw_base[15], cab_mode ^ probe, sw_base[13:0]};

  boot_config_readback #(.STATION_IMAGE(IMG)) dut (
    .MCLK        (MCLK),
    .SRST        (SRST),
    .BUS         (bus),
    .SW          (sw_in),
    .ROM_DATA    (rom_data),
    .BUSY        (busy),
    .ACK         (ack),
    .RDATA       (rdata),
    .ROM_ADDR    (rom_addr),
    .CABLE_PROBE (probe),
    .HALT_REQ    (halt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checking and reporting helpers
  task automatic check32(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic check1(input string nm, input logic exp, input logic got);
    check32(nm, {31'h0, exp}, {31'h0, got});
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard; the whole run needs about seven hundred and fifty cycles
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("[FAIL] run length expected under 20000 seen 20000");
      conclude();
    end
  end

  function automatic logic [31:0] exp_cfg(input logic [15:0] s, input logic [4:0] idx);
    return {s[15], 4'h0, s[13:11], 5'h00, s[10:8], IMG[idx*8+:8], s[7:3], 1'b1, s[2:1]};
  endfunction

  // Lanes kept by a read of the given size, other lanes zero
  function automatic logic [31:0] exp_lane(input xfer_size_t s, input logic [1:0] ad,
                                           input logic [31:0] d);
    logic [31:0] r;
    r = 32'h0;
    for (int b = 0; b < 4; b++)
      if (s == SZ_LONG || (s == SZ_WORD && b[1] == ad[1]) || (s == SZ_BYTE && b == ad))
        r[b*8+:8] = d[b*8+:8];
    return r;
  endfunction

  // One reference: pulse taken at a rising edge, then wait boundedly for the answer
  task automatic access(input logic w, input logic ext, input xfer_size_t s,
                        input logic [31:0] ad, input logic [31:0] wd,
                        output logic [31:0] r, output logic acked);
    @(negedge MCLK);
    bus = '{req: 1'b1, wr: w, ext_master: ext, size: s, addr: ad, wdata: wd};
    @(negedge MCLK);
    busy_seen = busy;
    bus.req = 1'b0;
    acked = 1'b0;
    r = 32'h0;
    for (int i = 0; i < 6 && !acked; i++) begin
      @(posedge MCLK);
      #1;
      if (ack === 1'b1) begin
        acked = 1'b1;
        r = rdata;
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (12) @(posedge MCLK);
    #1;
    check1("ack in reset", 1'b0, ack);
    check32("rdata in reset", 32'h0, rdata);
    @(negedge MCLK) SRST = 1'b0;
    // Every offset under several switch settings, every baud and mode code
    for (int rep = 0; rep < 8; rep++) begin
      v = $random(seed);
      sw_base = (rep == 0) ? 16'h0000 : (rep == 7) ? 16'hFFFF : v[15:0];
      sw_base[6:4] = rep[2:0];
      sw_base[2:1] = rep[1:0];
      repeat (5) @(posedge MCLK);
      for (int idx = 0; idx < 32; idx++) begin
        access(1'b0, 1'b0, SZ_LONG, CFG_REG_BASE + idx * 4, 32'h0, rd, ok);
        check1("cfg ack", 1'b1, ok);
        check1("cfg busy", 1'b1, busy_seen);
        e = exp_cfg(sw_base, idx[4:0]);
        check32("cfg word", e, rd & CMP_MASK);
        check32("cfg low byte", {24'h0, e[7:0]}, {24'h0, rd[7:0]});
        check32("cfg station", {24'h0, IMG[idx*8+:8]}, {24'h0, rd[15:8]});
      end
    end
    $display("test cfg sweep done");
    // Writes complete and change nothing
    for (int k = 0; k < 2; k++) begin
      a = CFG_REG_BASE + (k ? 32'h7C : 32'h1C);
      access(1'b1, 1'b0, SZ_LONG, a, k ? 32'hFFFF_FFFF : 32'h0, rd, ok);
      check1("cfg write ack", 1'b1, ok);
      check32("cfg write data", 32'h0, rd);
      access(1'b0, 1'b0, SZ_LONG, a, 32'h0, rd, ok);
      check32("cfg after write", exp_cfg(sw_base, a[6:2]), rd & CMP_MASK);
    end
    // Refused references: external master and first address past the range
    access(1'b0, 1'b1, SZ_LONG, CFG_REG_BASE, 32'h0, rd, ok);
    check1("external master ack", 1'b0, ok);
    check1("external master busy", 1'b0, busy_seen);
    access(1'b0, 1'b0, SZ_LONG, CFG_REG_BASE + 32'h80, 32'h0, rd, ok);
    check1("past range ack", 1'b0, ok);
    // Request held across the busy cycle: only the first edge may take it
    @(negedge MCLK);
    bus = '{req: 1'b1, wr: 1'b0, ext_master: 1'b0, size: SZ_LONG, addr: CFG_REG_BASE,
            wdata: 32'h0};
    @(negedge MCLK);
    check1("held req busy", 1'b1, busy);
    @(negedge MCLK);
    check1("held req ack", 1'b1, ack);
    bus.req = 1'b0;
    ack_cnt = 0;
    repeat (6) begin
      @(posedge MCLK);
      #1;
      if (ack === 1'b1) ack_cnt++;
    end
    check32("req while busy acks", 32'h0, ack_cnt);
    $display("test writes and refusals done");
    // Cable loop straight then reversed
    for (int k = 0; k < 2; k++) begin
      cab_mode = k[0];
      repeat (40) @(posedge MCLK);
      access(1'b0, 1'b0, SZ_LONG, CFG_REG_BASE + 32'h40, 32'h0, rd, ok);
      check1("cable fault bit", k[0], rd[30]);
    end
    $display("test cable done");
    // Break halts only while the halt-on-break switch is set
    for (int k = 0; k < 4; k++) begin
      sw_base[7] = k[1];
      sw_base[0] = k[0];
      repeat (6) @(posedge MCLK);
      #1;
      check1("halt request", k == 3, halt);
      // Firmware view: halt-on-break bit picks console or boot path
      access(1'b0, 1'b0, SZ_LONG, CFG_REG_BASE, 32'h0, rd, ok);
      check1("halt allow bit", k[1], rd[7]);
    end
    $display("test halt done");
    // EPROM reads of all sizes at random places
    for (int k = 0; k < 12; k++) begin
      sz = xfer_size_t'(k % 3);
      v = $random(seed);
      a = EPROM_BASE + (v & 32'h0003_FFFF);
      access(1'b0, 1'b0, sz, a, 32'h0, rd, ok);
      check32("rom index", {16'h0, a[17:2]}, {16'h0, rom_addr});
      check32("rom data", exp_lane(sz, a[1:0], {a[17:2], ~a[17:2]}), rd);
    end
    // Battery RAM: long write, byte write, then byte and word reads
    v = $random(seed);
    a = NVRAM_BASE + (v & 32'h0000_03FC);
    v = $random(seed);
    access(1'b1, 1'b0, SZ_LONG, a, v, rd, ok);
    access(1'b0, 1'b0, SZ_LONG, a, 32'h0, rd, ok);
    check32("ram long", v, rd);
    access(1'b1, 1'b0, SZ_BYTE, a + 2, 32'h003C_0000, rd, ok);
    v[23:16] = 8'h3C;
    access(1'b0, 1'b0, SZ_BYTE, a + 2, 32'h0, rd, ok);
    check32("ram byte", exp_lane(SZ_BYTE, 2'h2, v), rd);
    access(1'b0, 1'b0, SZ_WORD, a + 3, 32'h0, rd, ok);
    check32("ram word", exp_lane(SZ_WORD, 2'h3, v), rd);
    $display("test memories done");
    conclude();
  end
endmodule // boot_config_readback_test
